// ---- bench/tec16_asserts.sv ----
// Port-level assertions for the 16-bit timer core
`timescale 1ns/10ps
`include "tmr16_consts.vh"
module tec16_asserts #(
  parameter CNT_W = 16
) (
  input wire        clk,
  input wire        sys_rst,
  input wire [5:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        event_in_pin,
  input wire        wave_out_pin,
  input wire        match_irq,
  input wire        capture_irq
);
  // ----------------------------------------
  // Shadow of software settings
  // ----------------------------------------
  reg  [2:0] mode_r;
  reg  [1:0] out_r;
  reg  [1:0] edge_r;
  reg  [1:0] oc_age_r;
  wire       wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire       oc_wr = wr_ok & (avs_address == `TMR_ADDR_OUTCTL);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r   <= 3'h0;
      out_r    <= 2'h0;
      edge_r   <= 2'h0;
      oc_age_r <= 2'h0;
    end else begin
      if (wr_ok && avs_address == `TMR_ADDR_MODE) mode_r <= avs_writedata[3:1];
      if (wr_ok && avs_address == `TMR_ADDR_EDGE) edge_r <= avs_writedata[3:2];
      if (oc_wr) out_r <= avs_writedata[1:0];
      oc_age_r <= oc_wr ? 2'h0 : oc_age_r + {1'b0, oc_age_r != 2'h3};
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_req_new; $rose(avs_read | avs_write); endsequence
  sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  // Noise pulse one cycle wide after a quiet input
  sequence s_glitch;
    $stable(event_in_pin)[*6] ##1 $changed(event_in_pin) ##1 $changed(event_in_pin);
  endsequence

  property p_wait_once; s_req_new |-> s_one_wait; endproperty
  property p_match_pulse; match_irq |=> !match_irq; endproperty
  property p_cap_pulse; capture_irq |=> !capture_irq; endproperty
  property p_glitch; s_glitch |=> !capture_irq [*4]; endproperty
  property p_stop_quiet;
    mode_r == 3'h0 && $past(mode_r) == 3'h0 && $past(mode_r, 2) == 3'h0 |-> !match_irq;
  endproperty
  property p_hold_out; !out_r[0] && oc_age_r == 2'h3 |-> $stable(wave_out_pin); endproperty
  property p_square;
    !mode_r[0] && mode_r != 3'h0 && out_r == 2'h3 && match_irq |-> ##[0:2] $changed(wave_out_pin);
  endproperty
  property p_edge_pol; capture_irq && !edge_r[1] |-> $past(event_in_pin, 3) == edge_r[0];
  endproperty

  a_wait_once: assert property (p_wait_once) else $error("bus wait count wrong");
  a_match_pulse: assert property (p_match_pulse) else $error("match pulse too long");
  a_cap_pulse: assert property (p_cap_pulse) else $error("capture pulse too long");
  a_glitch: assert property (p_glitch) else $error("noise pulse accepted");
  a_stop_quiet: assert property (p_stop_quiet) else $error("match while stopped");
  a_hold_out: assert property (p_hold_out) else $error("output moved while disabled");
  a_square: assert property (p_square) else $error("no toggle on match");
  a_edge_pol: assert property (p_edge_pol) else $error("wrong edge accepted");
endmodule

bind tmr16_core tec16_asserts #(.CNT_W(CNT_W)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .event_in_pin(event_in_pin), .wave_out_pin(wave_out_pin), .match_irq(match_irq),
  .capture_irq(capture_irq)
);

// ---- bench/tec16_pulse_src.sv ----
// Behavioural external pulse source on the event input pin
`timescale 1ns/10ps
module tec16_pulse_src (
  input  wire clk,
  output reg  pin
);
  initial pin = 1'b0;

  // Hold of one cycle makes a noise pulse
  task automatic drive(input reg lvl, input integer hold);
    begin
      @(posedge clk);
      pin <= lvl;
      repeat (hold - 1) @(posedge clk);
    end
  endtask

  task automatic toggle(input integer h, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) drive(~pin, h);
    end
  endtask
endmodule

// ---- bench/timer16_event_counter_ops_tb_top.sv ----
// Self-checking bench for the 16-bit timer/event counter core
`timescale 1ns/10ps
`include "tmr16_consts.vh"
module timer16_event_counter_ops_tb_top;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [5:0]  avs_address = 6'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire        event_in_pin;
  wire        wave_out_pin;
  wire        match_irq;
  wire        capture_irq;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     m_cnt = 0;
  integer     c_cnt = 0;
  integer     t0, hi, rise, m0;
  reg  [31:0] q, q0;
  reg  [5:0]  a;
  reg  [2:0]  c;

  always #2.5 clk = ~clk;

  tmr16_core #(.CNT_W(16)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_in_pin(event_in_pin), .wave_out_pin(wave_out_pin), .match_irq(match_irq),
    .capture_irq(capture_irq)
  );
  tec16_pulse_src src_u (.clk(clk), .pin(event_in_pin));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test;
    begin
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task automatic chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
    end
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic xfer(input w, input [5:0] ad, input [31:0] d, output [31:0] rq);
    begin
      @(posedge clk);
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rq = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task automatic wr(input [5:0] ad, input [31:0] d);
    reg [31:0] dummy;
    begin
      xfer(1'b1, ad, d, dummy);
    end
  endtask

  task automatic wait_irq(input sel);
    begin
      @(posedge clk);
      while ((sel ? capture_irq : match_irq) !== 1'b1) @(posedge clk);
    end
  endtask

  task automatic meas(input integer len, output integer h, output integer r);
    reg     p;
    integer i;
    begin
      h = 0;
      r = 0;
      repeat (4) @(posedge clk);
      p = wave_out_pin;
      for (i = 0; i < len; i = i + 1) begin
        @(posedge clk);
        if (wave_out_pin === 1'b1) h = h + 1;
        if (wave_out_pin === 1'b1 && p === 1'b0) r = r + 1;
        p = wave_out_pin;
      end
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (match_irq === 1'b1) m_cnt <= m_cnt + 1;
    if (capture_irq === 1'b1) c_cnt <= c_cnt + 1;
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (a = 6'h00; a <= 6'h20; a = a + 6'h04) begin
      xfer(1'b0, a, 32'h0, q);
      chk(q, a == `TMR_ADDR_COMPARE ? `TMR_RST_COMPARE : 32'h0);
    end
    for (c = 3'h1; c <= 3'h4; c = c + 3'h1) begin
      wr(`TMR_ADDR_MODE, 32'h00);
      wr(`TMR_ADDR_CLKSEL, {25'h0, c, 4'h0});
      wr(`TMR_ADDR_COMPARE, 32'h04);
      wr(`TMR_ADDR_MODE, 32'h0C);
      wait_irq(1'b0);
      t0 = cyc;
      wait_irq(1'b0);
      chk(cyc - t0, 5 << (c - 1));
    end
    wr(`TMR_ADDR_MODE, 32'h00);
    m0 = m_cnt;
    xfer(1'b0, `TMR_ADDR_COUNT, 32'h0, q);
    chk(q, 32'h0);
    repeat (30) @(posedge clk);
    chk(m_cnt, m0);
    wr(`TMR_ADDR_CLKSEL, 32'h00);
    wr(`TMR_ADDR_EDGE, 32'h04);
    wr(`TMR_ADDR_COMPARE, 32'h03);
    wr(`TMR_ADDR_MODE, 32'h0C);
    repeat (3) begin
      src_u.drive(1'b1, 8);
      src_u.drive(1'b0, 8);
    end
    xfer(1'b0, `TMR_ADDR_COUNT, 32'h0, q);
    chk(q, 32'h3);
    src_u.drive(1'b1, 8);
    src_u.drive(1'b0, 8);
    chk(m_cnt, m0 + 1);
    m0 = c_cnt;
    src_u.drive(1'b1, 1);
    src_u.drive(1'b0, 10);
    chk(c_cnt, m0);
    xfer(1'b0, `TMR_ADDR_COUNT, 32'h0, q);
    chk(q, 32'h0);
    wr(`TMR_ADDR_MODE, 32'h00);
    wr(`TMR_ADDR_EDGE, 32'h0C);
    wr(`TMR_ADDR_CLKSEL, 32'h10);
    wr(`TMR_ADDR_MODE, 32'h04);
    fork
      src_u.toggle(40, 2);
      begin
        wait_irq(1'b1);
        xfer(1'b0, `TMR_ADDR_CAPTURE, 32'h0, q0);
        wait_irq(1'b1);
        xfer(1'b0, `TMR_ADDR_CAPTURE, 32'h0, q);
      end
    join
    chk(q - q0, 32'd40);
    wr(`TMR_ADDR_MODE, 32'h00);
    wr(`TMR_ADDR_EDGE, 32'h00);
    wr(`TMR_ADDR_MODE, 32'h08);
    fork
      src_u.toggle(40, 4);
      begin
        wait_irq(1'b1);
        wait_irq(1'b1);
        xfer(1'b0, `TMR_ADDR_CAPTURE, 32'h0, q);
      end
    join
    chk(q, 32'd79);
    wr(`TMR_ADDR_MODE, 32'h00);
    wr(`TMR_ADDR_OUTCTL, 32'h01);
    wr(`TMR_ADDR_MODE, 32'h02);
    wr(`TMR_ADDR_COMPARE, 32'h48C);
    meas(16384, hi, rise);
    chk(hi, 32'd291);
    chk(rise, 32'd64);
    wr(`TMR_ADDR_MODE, 32'h00);
    wr(`TMR_ADDR_OUTCTL, 32'h03);
    wr(`TMR_ADDR_MODE, 32'h02);
    meas(16384, hi, rise);
    chk(16384 - hi, 32'd291);
    wr(`TMR_ADDR_MODE, 32'h00);
    wr(`TMR_ADDR_OUTCTL, 32'h04);
    wr(`TMR_ADDR_MODE, 32'h02);
    meas(200, hi, rise);
    chk(hi, 32'd0);
    wr(`TMR_ADDR_MODE, 32'h00);
    wr(`TMR_ADDR_OUTCTL, 32'h0B);
    meas(50, hi, rise);
    chk(hi, 32'd50);
    wr(`TMR_ADDR_COMPARE, 32'h09);
    wr(`TMR_ADDR_MODE, 32'h0C);
    @(posedge clk);
    while (wave_out_pin !== 1'b0) @(posedge clk);
    t0 = cyc;
    while (wave_out_pin === 1'b0) @(posedge clk);
    chk(cyc - t0, 32'd10);
    finish_test;
  end
endmodule

// ---- inc/tmr16_consts.vh ----
// Register map, field positions, reset values and codes of the 16-bit timer
`ifndef TMR16_CONSTS_VH
`define TMR16_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses (word aligned)
// ----------------------------------------------------------------
`define TMR_ADDR_MODE     6'h00
`define TMR_ADDR_CLKSEL   6'h04
`define TMR_ADDR_OUTCTL   6'h08
`define TMR_ADDR_EDGE     6'h0C
`define TMR_ADDR_SAMPLE   6'h10
`define TMR_ADDR_COMPARE  6'h14
`define TMR_ADDR_CAPTURE  6'h18
`define TMR_ADDR_COUNT    6'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMR_MODE_OVF      0
`define TMR_MODE_LSB      1
`define TMR_MODE_MSB      3
`define TMR_CLK_LSB       4
`define TMR_CLK_MSB       6
`define TMR_OUT_OE        0
`define TMR_OUT_ALV       1
`define TMR_OUT_LVR       2
`define TMR_OUT_LVS       3
`define TMR_EDGE_LSB      2
`define TMR_EDGE_MSB      3
`define TMR_SMP_LSB       0
`define TMR_SMP_MSB       1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMR_RST_MODE      3'h0
`define TMR_RST_CLKSEL    3'h0
`define TMR_RST_EDGE      2'h0
`define TMR_RST_SAMPLE    2'h0
`define TMR_RST_COMPARE   16'hFFFF
`define TMR_RST_COUNT     16'h0000

// ----------------------------------------------------------------
// Mode codes (bit3, bit2, bit1)
// ----------------------------------------------------------------
`define TMR_MODE_STOP     3'h0
`define TMR_MODE_PWM      3'h1

// ----------------------------------------------------------------
// Count clock codes
// ----------------------------------------------------------------
`define TMR_CLK_EVENT     3'h0
`define TMR_CLK_DIV1      3'h1
`define TMR_CLK_DIV2      3'h2
`define TMR_CLK_DIV4      3'h3
`define TMR_CLK_DIV8      3'h4

// ----------------------------------------------------------------
// Edge select codes
// ----------------------------------------------------------------
`define TMR_EDGE_FALL     2'h0
`define TMR_EDGE_RISE     2'h1
`define TMR_EDGE_BOTH     2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TMR_PRESC_W       3
`define TMR_PWM_BASE_W    8
`define TMR_PWM_SUB_W     6

`endif

// ---- logic/tmr16_core.v ----
// 16-bit timer/event counter with PWM, capture and Avalon-MM register slave
//
// Functional notes
// - Mode bits 3 and 2 both set give a repeating interval timer.
// - Interval mode: count equal to compare clears count, keeps counting, pulses match_irq.
// - count_clk_sel: 0 event edges, 1..4 clock divided by 1, 2, 4, 8.
// - Mode code 001 selects PWM output on wave_out_pin.
// - PWM active width uses the upper 14 compare bits.
// - PWM active level from active_level_sel; output_enable_bit gates the output.
// - PWM spreads active time: 2^8 basic cycle within 2^14 sub-cycle.
// - Free-running mode: valid edge copies count to capture, pulses capture_irq.
// - Valid edge is rising, falling or both via edge_sel bits 2 and 3.
// - Edge accepted only after the new level is sampled twice in a row.
// - Restart mode: valid edge captures count, then clears and restarts count.
// - Event counting: count steps per valid edge, clears on match, pulses match_irq.
// - Enable and active_level_sel both set: output toggles on every interval.
// - level_reset_bit and level_set_bit preset the output level.
// - First match may come up to one count clock early after start.
// - Compare lowered below count: count wraps through overflow to zero.
// - Edge during capture read keeps old capture but still pulses capture_irq.
// - Mode 000 stops, holds count at zero, output unchanged, no match_irq.
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`include "tmr16_consts.vh"

module tmr16_core #(
  parameter CNT_W = 16
) (
  input  wire              clk,
  input  wire              sys_rst,
  input  wire [5:0]        avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  input  wire [3:0]        avs_byteenable,
  output reg  [31:0]       avs_readdata,
  output wire              avs_waitrequest,
  input  wire              event_in_pin,
  output reg               wave_out_pin,
  output reg               match_irq,
  output reg               capture_irq
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg  [2:0]       mode_r;
  reg              ovf_r;
  reg  [2:0]       clk_sel_r;
  reg              oe_r;
  reg              alv_r;
  reg  [1:0]       edge_sel_r;
  reg  [1:0]       smp_sel_r;
  reg  [CNT_W-1:0] compare_r;
  reg  [CNT_W-1:0] capture_r;
  reg  [CNT_W-1:0] count_r;
  reg  [CNT_W-1:0] count_nxt;
  reg              level_r;
  reg              ack_r;
  reg  [`TMR_PRESC_W-1:0] div_r;

  wire             bus_req;
  wire             wr_ok;
  wire             be0;
  wire             be1;
  wire             stopped;
  wire             pwm_mode;
  wire             free_mode;
  wire             restart_mode;
  wire             interval_mode;
  wire             edge_toggle;
  wire             valid_edge;
  wire             cap_read;
  wire             at_match;
  wire             mode_wr;
  reg              tick;
  reg              smp_en;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, answer in the second cycle
  // ----------------------------------------------------------------
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign wr_ok           = avs_write & ack_r;
  assign be0             = avs_byteenable[0];
  assign be1             = avs_byteenable[1];
  assign mode_wr         = wr_ok & be0 & (avs_address == `TMR_ADDR_MODE);

  // Whole read request window counts as a capture read
  assign cap_read = avs_read & (avs_address == `TMR_ADDR_CAPTURE);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (avs_read & ~ack_r) begin
        case (avs_address)
          `TMR_ADDR_MODE:    avs_readdata <= {28'h0000000, mode_r, ovf_r};
          `TMR_ADDR_CLKSEL:  avs_readdata <= {25'h0000000, clk_sel_r, 4'h0};
          // Preset bits always read back as zero
          `TMR_ADDR_OUTCTL:  avs_readdata <= {30'h00000000, alv_r, oe_r};
          `TMR_ADDR_EDGE:    avs_readdata <= {28'h0000000, edge_sel_r, 2'h0};
          `TMR_ADDR_SAMPLE:  avs_readdata <= {30'h00000000, smp_sel_r};
          `TMR_ADDR_COMPARE: avs_readdata <= {{(32-CNT_W){1'b0}}, compare_r};
          `TMR_ADDR_CAPTURE: avs_readdata <= {{(32-CNT_W){1'b0}}, capture_r};
          `TMR_ADDR_COUNT:   avs_readdata <= {{(32-CNT_W){1'b0}}, count_r};
          default:           avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r     <= `TMR_RST_MODE;
      clk_sel_r  <= `TMR_RST_CLKSEL;
      oe_r       <= 1'b0;
      alv_r      <= 1'b0;
      edge_sel_r <= `TMR_RST_EDGE;
      smp_sel_r  <= `TMR_RST_SAMPLE;
      compare_r  <= `TMR_RST_COMPARE;
    end else if (wr_ok) begin
      case (avs_address)
        `TMR_ADDR_MODE: begin
          if (be0) begin
            mode_r <= avs_writedata[`TMR_MODE_MSB:`TMR_MODE_LSB];
          end
        end
        `TMR_ADDR_CLKSEL: begin
          if (be0) begin
            clk_sel_r <= avs_writedata[`TMR_CLK_MSB:`TMR_CLK_LSB];
          end
        end
        `TMR_ADDR_OUTCTL: begin
          if (be0) begin
            oe_r  <= avs_writedata[`TMR_OUT_OE];
            alv_r <= avs_writedata[`TMR_OUT_ALV];
          end
        end
        `TMR_ADDR_EDGE: begin
          if (be0) begin
            edge_sel_r <= avs_writedata[`TMR_EDGE_MSB:`TMR_EDGE_LSB];
          end
        end
        `TMR_ADDR_SAMPLE: begin
          if (be0) begin
            smp_sel_r <= avs_writedata[`TMR_SMP_MSB:`TMR_SMP_LSB];
          end
        end
        `TMR_ADDR_COMPARE: begin
          if (be0) begin
            compare_r[7:0] <= avs_writedata[7:0];
          end
          if (be1) begin
            compare_r[15:8] <= avs_writedata[15:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign stopped       = (mode_r == `TMR_MODE_STOP);
  assign pwm_mode      = (mode_r == `TMR_MODE_PWM);
  assign free_mode     = (mode_r[2:1] == 2'b01);
  assign restart_mode  = (mode_r[2:1] == 2'b10);
  assign interval_mode = (mode_r[2:1] == 2'b11);
  assign edge_toggle   = mode_r[0] & ~pwm_mode;

  // ----------------------------------------------------------------
  // Prescaler, count clock and sampling enables
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= {`TMR_PRESC_W{1'b0}};
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  always @* begin
    case (clk_sel_r)
      `TMR_CLK_EVENT: tick = valid_edge;
      `TMR_CLK_DIV1:  tick = 1'b1;
      `TMR_CLK_DIV2:  tick = div_r[0];
      `TMR_CLK_DIV4:  tick = &div_r[1:0];
      `TMR_CLK_DIV8:  tick = &div_r[2:0];
      default:        tick = 1'b0;
    endcase
  end

  always @* begin
    case (smp_sel_r)
      2'h0:    smp_en = 1'b1;
      2'h1:    smp_en = div_r[0];
      2'h2:    smp_en = &div_r[1:0];
      default: smp_en = &div_r[2:0];
    endcase
  end

  tmr16_edge u_edge (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .sample_en  (smp_en),
    .pin        (event_in_pin),
    .edge_sel   (edge_sel_r),
    .valid_edge (valid_edge)
  );

  // ----------------------------------------------------------------
  // Counter, capture and interrupt pulses
  // ----------------------------------------------------------------
  // Counting begins at the next count clock after start, so the first
  // interval can run up to one count clock short.
  assign at_match = tick & (count_r == compare_r);

  always @* begin
    count_nxt = count_r;
    if (stopped) begin
      count_nxt = `TMR_RST_COUNT;
    end else if (restart_mode & valid_edge) begin
      count_nxt = `TMR_RST_COUNT;
    end else if (interval_mode & at_match) begin
      count_nxt = `TMR_RST_COUNT;
    end else if (tick) begin
      // Compare below count: plain wrap through FFFF
      count_nxt = count_r + 1'b1;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r     <= `TMR_RST_COUNT;
      capture_r   <= {CNT_W{1'b0}};
      ovf_r       <= 1'b0;
      match_irq   <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      count_r     <= count_nxt;
      match_irq   <= at_match & ~stopped;
      capture_irq <= valid_edge;
      if (valid_edge & (free_mode | restart_mode) & ~cap_read) begin
        capture_r <= count_r;
      end
      // Set wins over a software clear in the same cycle
      if (~stopped & tick & (&count_r) & ~(interval_mode & at_match)) begin
        ovf_r <= 1'b1;
      end else if (mode_wr & ~avs_writedata[`TMR_MODE_OVF]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // PWM generator
  // ----------------------------------------------------------------
  // Duty D = compare[15:2]. Each 256-clock basic cycle is active for
  // D[13:6] clocks, plus one more in D[5:0] of the 64 basic cycles.
  // Spreading the extra clocks keeps ripple low for the filter.
  wire [13:0] pwm_duty;
  wire [5:0]  sub_idx;
  wire [5:0]  sub_rev;
  wire        pwm_extra;
  wire        pwm_active;
  wire [8:0]  pwm_width;

  assign pwm_duty = compare_r[15:2];
  assign sub_idx  = count_r[13:8];
  assign sub_rev  = {sub_idx[0], sub_idx[1], sub_idx[2],
                     sub_idx[3], sub_idx[4], sub_idx[5]};
  assign pwm_extra  = (sub_rev < pwm_duty[5:0]);
  assign pwm_width  = {1'b0, pwm_duty[13:6]} + {8'h00, pwm_extra};
  assign pwm_active = ({1'b0, count_r[7:0]} < pwm_width);

  // ----------------------------------------------------------------
  // Output level flip-flop and pin
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_r <= 1'b0;
    end else if (wr_ok & be0 & (avs_address == `TMR_ADDR_OUTCTL) &
                 (avs_writedata[`TMR_OUT_LVS] | avs_writedata[`TMR_OUT_LVR])) begin
      // Set takes priority when both presets are written
      level_r <= avs_writedata[`TMR_OUT_LVS];
    end else if (~stopped & ~pwm_mode & oe_r & alv_r &
                 (at_match | (edge_toggle & valid_edge))) begin
      level_r <= ~level_r;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wave_out_pin <= 1'b0;
    end else if (oe_r & pwm_mode) begin
      // Level select high gives an active-low pulse
      wave_out_pin <= pwm_active ^ alv_r;
    end else begin
      wave_out_pin <= level_r;
    end
  end

endmodule

// ---- logic/tmr16_edge.v ----
// Sampled two-in-a-row noise filter and valid edge detector for the event pin
`timescale 1ns/10ps
`include "tmr16_consts.vh"

module tmr16_edge (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       sample_en,
  input  wire       pin,
  input  wire [1:0] edge_sel,
  output reg        valid_edge
);

  reg  smp_r;
  reg  level_r;
  wire new_lvl;
  wire rise;
  wire fall;

  // ----------------------------------------------------------------
  // Level accepted only after two equal consecutive samples
  // ----------------------------------------------------------------
  assign new_lvl = sample_en & (pin == smp_r) & (pin != level_r);
  assign rise    = new_lvl & pin;
  assign fall    = new_lvl & ~pin;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      smp_r      <= 1'b0;
      level_r    <= 1'b0;
      valid_edge <= 1'b0;
    end else begin
      if (sample_en) begin
        smp_r <= pin;
      end
      if (new_lvl) begin
        level_r <= pin;
      end
      case (edge_sel)
        `TMR_EDGE_FALL: valid_edge <= fall;
        `TMR_EDGE_RISE: valid_edge <= rise;
        `TMR_EDGE_BOTH: valid_edge <= rise | fall;
        default:        valid_edge <= 1'b0;
      endcase
    end
  end

endmodule
